// ### src/pas_pkg.sv
// package: register map, field layout, source codes and states of the pwm auto-shutdown block
package pas_pkg;

  // wishbone geometry
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned IDX_W = 6;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] CTRL_IDX = 6'h17;
  localparam logic [IDX_W-1:0] STAT_IDX = 6'h18;
  localparam logic [IDX_W-1:0] MASK_IDX = 6'h19;
  localparam logic [IDX_W-1:0] SRCV_IDX = 6'h1a;

  // auto_shutdown_ctrl layout
  localparam int unsigned CTRL_W   = 8;
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned SEL_HI   = 6;
  localparam int unsigned SEL_LO   = 4;
  localparam int unsigned AC_HI    = 3;
  localparam int unsigned AC_LO    = 2;
  localparam int unsigned BD_HI    = 1;
  localparam int unsigned BD_LO    = 0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;

  // shutdown_source_sel codes
  localparam logic [2:0] SRC_OFF     = 3'h0;
  localparam logic [2:0] SRC_C1      = 3'h1;
  localparam logic [2:0] SRC_C2      = 3'h2;
  localparam logic [2:0] SRC_C12     = 3'h3;
  localparam logic [2:0] SRC_INT     = 3'h4;
  localparam logic [2:0] SRC_INT_C1  = 3'h5;
  localparam logic [2:0] SRC_INT_C2  = 3'h6;
  localparam logic [2:0] SRC_INT_C12 = 3'h7;

  // pair shutdown state codes; bit 1 set means high impedance
  localparam logic [1:0] PS_LOW  = 2'h0;
  localparam logic [1:0] PS_HIGH = 2'h1;
  localparam int unsigned PS_TRI_BIT = 1;

  // interrupt status / mask layout
  localparam int unsigned IRQ_W     = 2;
  localparam int unsigned IRQ_ENTER = 0;
  localparam int unsigned IRQ_EXIT  = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

  // source view layout
  localparam int unsigned SV_INT_LOW = 0;
  localparam int unsigned SV_C1      = 1;
  localparam int unsigned SV_C2      = 2;
  localparam int unsigned SV_FAULT   = 3;

  typedef enum logic {PAS_RUN, PAS_SHUT} pas_state_t;

  // true when the selected source is active
  function automatic logic pas_src_active(input logic [2:0] sel, input logic int_low,
                                          input logic c1, input logic c2);
    logic r;
    r = 1'b0;
    case (sel)
      SRC_OFF:     r = 1'b0;
      SRC_C1:      r = c1;
      SRC_C2:      r = c2;
      SRC_C12:     r = c1 | c2;
      SRC_INT:     r = int_low;
      SRC_INT_C1:  r = int_low | c1;
      SRC_INT_C2:  r = int_low | c2;
      SRC_INT_C12: r = int_low | c1 | c2;
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

endpackage

// ### src/pas_pin_if.sv
// interface: shutdown request and pair states toward the output pin stage
`timescale 1ns/1ps
interface pas_pin_if;
  logic       shut;
  logic [1:0] ac_state;
  logic [1:0] bd_state;
  logic [3:0] pwm;
  logic [3:0] pin;
  logic [3:0] oe_n;

  modport ctl  (output shut, ac_state, bd_state, pwm, input pin, oe_n);
  modport pins (input shut, ac_state, bd_state, pwm, output pin, oe_n);
endinterface

// ### src/pas_pin_ctl.sv
// module: pin stage that overrides the four pwm outputs in shutdown
`timescale 1ns/1ps
module pas_pin_ctl (
  // control and pins
  pas_pin_if.pins pif
);
  import pas_pkg::*;

  logic [1:0] st;

  // purely combinational so the override does not wait for a clock edge
  always_comb begin
    st       = 2'h0;
    pif.pin  = 4'h0;
    pif.oe_n = 4'h0;
    for (int i = 0; i < 4; i++) begin
      // index 0 = a, 1 = b, 2 = c, 3 = d; a pairs with c, b with d
      st = ((i % 2) == 0) ? pif.ac_state : pif.bd_state;
      if (!pif.shut) begin
        pif.pin[i]  = pif.pwm[i];
        pif.oe_n[i] = 1'b0;
      end else if (st[PS_TRI_BIT]) begin
        pif.pin[i]  = 1'b0;
        pif.oe_n[i] = 1'b1;
      end else begin
        pif.pin[i]  = (st == PS_HIGH);
        pif.oe_n[i] = 1'b0;
      end
    end
  end

endmodule

// ### src/pas_top.sv
// module: pwm auto-shutdown control with wishbone register access and interrupt
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
module pas_top (
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [pas_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [pas_pkg::DAT_W-1:0] wb_dat_i,
  output      logic [pas_pkg::DAT_W-1:0] wb_dat_o,
  output      logic                     wb_ack_o,
  // fault sources
  input  wire logic                     ext_int_n_i,
  input  wire logic                     comparator_one_i,
  input  wire logic                     comparator_two_i,
  // normal pwm drive from the enhanced capture pwm unit
  input  wire logic                     pwm_a_i,
  input  wire logic                     pwm_b_i,
  input  wire logic                     pwm_c_i,
  input  wire logic                     pwm_d_i,
  // pwm output pins
  output      logic                     pwm_out_a_o,
  output      logic                     pwm_out_a_oe_n_o,
  output      logic                     pwm_out_b_o,
  output      logic                     pwm_out_b_oe_n_o,
  output      logic                     pwm_out_c_o,
  output      logic                     pwm_out_c_oe_n_o,
  output      logic                     pwm_out_d_o,
  output      logic                     pwm_out_d_oe_n_o,
  // interrupt and status
  output      logic                     irq_o,
  output      logic                     shutdown_o
);
  import pas_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync1_nxt;
  logic [2:0] sync2_nxt;

  always_comb begin
    sync1_nxt = {comparator_two_i, comparator_one_i, ~ext_int_n_i};
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  logic int_low_s;
  logic c1_s;
  logic c2_s;

  assign int_low_s = sync2_r[0];
  assign c1_s      = sync2_r[1];
  assign c2_s      = sync2_r[2];

  // ---------------------------------------------------------------
  // wishbone decode
  // ---------------------------------------------------------------
  logic             req;
  logic [IDX_W-1:0] idx;
  logic             hit_ctrl;
  logic             hit_stat;
  logic             hit_mask;
  logic             hit_srcv;
  logic             wr_done;
  logic             rd_done;
  logic             ack_r;
  logic             ack_nxt;

  assign req      = wb_cyc_i & wb_stb_i;
  assign idx      = wb_adr_i[ADR_W-1:2];
  assign hit_ctrl = (idx == CTRL_IDX);
  assign hit_stat = (idx == STAT_IDX);
  assign hit_mask = (idx == MASK_IDX);
  assign hit_srcv = (idx == SRCV_IDX);
  // writes and read side effects happen on the edge where the master sees ack
  assign wr_done  = req & ack_r & wb_we_i & wb_sel_i[0];
  assign rd_done  = req & ack_r & ~wb_we_i;

  // ---------------------------------------------------------------
  // control register and shutdown state
  // ---------------------------------------------------------------
  logic [CTRL_W-2:0] cfg_r;
  logic [CTRL_W-2:0] cfg_nxt;
  pas_state_t        state_r;
  pas_state_t        state_nxt;

  logic [2:0] shutdown_source_sel;
  logic [1:0] pair_ac_shutdown_state;
  logic [1:0] pair_bd_shutdown_state;
  logic       shutdown_event_flag;
  logic       fault_raw;
  logic       fault_s;
  logic       sw_set;
  logic       sw_clr;

  assign shutdown_source_sel    = cfg_r[SEL_HI:SEL_LO];
  assign pair_ac_shutdown_state = cfg_r[AC_HI:AC_LO];
  assign pair_bd_shutdown_state = cfg_r[BD_HI:BD_LO];
  assign shutdown_event_flag    = (state_r == PAS_SHUT);

  // the unsynchronised copy only gates the pins, so no clocked logic sees it
  assign fault_raw = pas_src_active(shutdown_source_sel, ~ext_int_n_i,
                                    comparator_one_i, comparator_two_i);
  assign fault_s   = pas_src_active(shutdown_source_sel, int_low_s, c1_s, c2_s);

  assign sw_set = wr_done & hit_ctrl & wb_dat_i[FLAG_BIT];
  assign sw_clr = wr_done & hit_ctrl & ~wb_dat_i[FLAG_BIT];

  always_comb begin
    cfg_nxt   = cfg_r;
    state_nxt = state_r;
    if (wr_done && hit_ctrl) begin
      cfg_nxt = wb_dat_i[CTRL_W-2:0];
    end
    case (state_r)
      PAS_RUN: begin
        if (fault_s || sw_set) begin
          state_nxt = PAS_SHUT;
        end
      end
      PAS_SHUT: begin
        // a live source wins over a firmware clear, so the flag cannot drop under a fault
        if (sw_clr && !fault_s) begin
          state_nxt = PAS_RUN;
        end
      end
      default: begin
        state_nxt = PAS_SHUT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r   <= CTRL_RST[CTRL_W-2:0];
      state_r <= PAS_RUN;
    end else begin
      cfg_r   <= cfg_nxt;
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] stat_r;
  logic [IRQ_W-1:0] stat_nxt;
  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] mask_nxt;
  logic [IRQ_W-1:0] events;

  always_comb begin
    events             = '0;
    events[IRQ_ENTER]  = (state_r == PAS_RUN) && (state_nxt == PAS_SHUT);
    events[IRQ_EXIT]   = (state_r == PAS_SHUT) && (state_nxt == PAS_RUN);
    stat_nxt           = stat_r;
    if (rd_done && hit_stat) begin
      stat_nxt = '0;
    end
    // a new event in the clearing cycle is kept
    stat_nxt = stat_nxt | events;
    mask_nxt = mask_r;
    if (wr_done && hit_mask) begin
      mask_nxt = wb_dat_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= IRQ_RST;
      mask_r <= IRQ_RST;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign irq_o = |(stat_r & mask_r);

  // ---------------------------------------------------------------
  // read data and acknowledge
  // ---------------------------------------------------------------
  logic [DAT_W-1:0] rdat_r;
  logic [DAT_W-1:0] rdat_nxt;

  always_comb begin
    ack_nxt  = req & ~ack_r;
    rdat_nxt = rdat_r;
    if (req && !ack_r) begin
      rdat_nxt = '0;
      // unmapped indices are acknowledged and read as zero
      if (hit_ctrl) begin
        rdat_nxt[CTRL_W-1:0] = {shutdown_event_flag, cfg_r};
      end else if (hit_stat) begin
        rdat_nxt[IRQ_W-1:0] = stat_r;
      end else if (hit_mask) begin
        rdat_nxt[IRQ_W-1:0] = mask_r;
      end else if (hit_srcv) begin
        rdat_nxt[SV_INT_LOW] = int_low_s;
        rdat_nxt[SV_C1]      = c1_s;
        rdat_nxt[SV_C2]      = c2_s;
        rdat_nxt[SV_FAULT]   = fault_s;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= '0;
    end else begin
      ack_r  <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ---------------------------------------------------------------
  // pin stage
  // ---------------------------------------------------------------
  pas_pin_if pif ();

  // the raw fault term forces the pins before the flag is even registered
  assign pif.shut     = shutdown_event_flag | fault_raw;
  assign pif.ac_state = pair_ac_shutdown_state;
  assign pif.bd_state = pair_bd_shutdown_state;
  assign pif.pwm      = {pwm_d_i, pwm_c_i, pwm_b_i, pwm_a_i};

  pas_pin_ctl u_pin_ctl (
    .pif (pif.pins)
  );

  assign pwm_out_a_o      = pif.pin[0];
  assign pwm_out_b_o      = pif.pin[1];
  assign pwm_out_c_o      = pif.pin[2];
  assign pwm_out_d_o      = pif.pin[3];
  assign pwm_out_a_oe_n_o = pif.oe_n[0];
  assign pwm_out_b_oe_n_o = pif.oe_n[1];
  assign pwm_out_c_oe_n_o = pif.oe_n[2];
  assign pwm_out_d_oe_n_o = pif.oe_n[3];
  assign shutdown_o       = pif.shut;

endmodule

// ### dv/pas_power_stage.sv
// power stage model: resolves each pwm pin, pulled low when not driven
`timescale 1ns/1ps
module pas_power_stage (
  // pins from the block
  input  wire logic [3:0] pin_i,
  input  wire logic [3:0] oe_n_i,
  // level seen by the gate drivers
  output      logic [3:0] lvl_o
);
  // a released pin settles to the pull-down, never to its last level
  assign lvl_o = pin_i & ~oe_n_i;
endmodule

// ### dv/pas_top_checker.sv
// checker: bus handshake, source decode and pin override of pas_top
`timescale 1ns/1ps
module pas_top_checker
  import pas_pkg::*;
(
  // clock, reset and bus
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [ADR_W-1:0]   wb_adr_i,
  input wire logic [3:0]         wb_sel_i,
  input wire logic [DAT_W-1:0]   wb_dat_i,
  input wire logic [DAT_W-1:0]   wb_dat_o,
  input wire logic               wb_ack_o,
  // sources and pins
  input wire logic               ext_int_n_i,
  input wire logic               comparator_one_i,
  input wire logic               comparator_two_i,
  input wire logic               pwm_a_i,
  input wire logic               pwm_b_i,
  input wire logic               pwm_c_i,
  input wire logic               pwm_d_i,
  input wire logic               pwm_out_a_o,
  input wire logic               pwm_out_a_oe_n_o,
  input wire logic               pwm_out_b_o,
  input wire logic               pwm_out_b_oe_n_o,
  input wire logic               pwm_out_c_o,
  input wire logic               pwm_out_c_oe_n_o,
  input wire logic               pwm_out_d_o,
  input wire logic               pwm_out_d_oe_n_o,
  input wire logic               shutdown_o
);
  logic [6:0] ctrl_r;
  logic [6:0] ctrl_nxt;
  logic       src_act;
  logic       wr_ctrl;
  logic [3:0] pin;
  logic [3:0] oe;
  assign pin = {pwm_out_d_o, pwm_out_c_o, pwm_out_b_o, pwm_out_a_o};
  assign oe = {pwm_out_d_oe_n_o, pwm_out_c_oe_n_o, pwm_out_b_oe_n_o, pwm_out_a_oe_n_o};
  assign wr_ctrl = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h5c;
  // each select bit gates one source, so the eight codes need no table
  assign src_act = (ctrl_r[4] & comparator_one_i) | (ctrl_r[5] & comparator_two_i) | (ctrl_r[6] & !ext_int_n_i);
  always_comb begin
    ctrl_nxt = wr_ctrl ? wb_dat_i[6:0] : ctrl_r;
  end
  always_ff @(posedge clk_i) begin
    ctrl_r <= rst_i ? 7'h00 : ctrl_nxt;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_start;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence src_held;
    src_act [*4] ##1 (!src_act && !wr_ctrl);
  endsequence
  a_ack_after_req: assert property (req_start |=> wb_ack_o) else $error("ack late");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ctrl_read_back: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h5c |->
    wb_dat_o[6:0] == ctrl_r && wb_dat_o[31:8] == 24'h0) else $error("ctrl readback wrong");
  a_src_forces_now: assert property (src_act |-> shutdown_o) else $error("source not forcing");
  a_flag_holds_pins: assert property (src_held |-> shutdown_o) else $error("flag dropped");
  a_run_passes_pwm: assert property (!shutdown_o |-> oe == 4'h0 &&
    pin == {pwm_d_i, pwm_c_i, pwm_b_i, pwm_a_i}) else $error("pwm not passed");
  a_shut_ac_pair: assert property (shutdown_o |-> (ctrl_r[3] ? oe[2] && oe[0] :
    !oe[2] && !oe[0] && pin[2] == ctrl_r[2] && pin[0] == ctrl_r[2])) else $error("a/c state wrong");
  a_shut_bd_pair: assert property (shutdown_o |-> (ctrl_r[1] ? oe[3] && oe[1] :
    !oe[3] && !oe[1] && pin[3] == ctrl_r[0] && pin[1] == ctrl_r[0])) else $error("b/d state wrong");
endmodule

// ### dv/testbench.sv
// testbench: register, source, pin state and interrupt scenarios for pas_top
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, ext_int_n_i = 1'b1, comparator_one_i = 1'b0, comparator_two_i = 1'b0;
  logic pwm_a_i = 1'b0, pwm_b_i = 1'b0, pwm_c_i = 1'b0, pwm_d_i = 1'b0, irq_o, shutdown_o;
  logic pwm_out_a_o, pwm_out_a_oe_n_o, pwm_out_b_o, pwm_out_b_oe_n_o;
  logic pwm_out_c_o, pwm_out_c_oe_n_o, pwm_out_d_o, pwm_out_d_oe_n_o;
  logic [3:0] oe, lvl;
  int n_fail = 0, checked = 0, cyc_cnt = 0;
  pas_top i_dut (.*);
  assign oe = {pwm_out_d_oe_n_o, pwm_out_c_oe_n_o, pwm_out_b_oe_n_o, pwm_out_a_oe_n_o};
  pas_power_stage i_stage (.pin_i({pwm_out_d_o, pwm_out_c_o, pwm_out_b_o, pwm_out_a_o}), .oe_n_i(oe), .lvl_o(lvl));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    {pwm_d_i, pwm_c_i, pwm_b_i, pwm_a_i} <= {pwm_d_i, pwm_c_i, pwm_b_i, pwm_a_i} + 4'h3;
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic cycle; returns one edge after ack so requests never abut
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    wb(0, 8'h5c, 0, q);
    chk("ctrl", 32'h0, q);
    wb(1, 8'h00, 32'hff, q);
    wb(0, 8'h00, 0, q);
    chk("unmapped", 32'h0, q);
    wb(0, 8'h68, 0, q);
    chk("srcview", 32'h0, q);
    $display("done reset");
  endtask
  task automatic t_src();
    logic [31:0] q;
    logic e;
    for (int s = 0; s < 8; s++)
      for (int k = 0; k < 3; k++) begin
        wb(1, 8'h5c, {25'h0, s[2:0], 4'h4}, q);
        ext_int_n_i <= (k != 0);
        comparator_one_i <= (k == 1);
        comparator_two_i <= (k == 2);
        e = (k == 0) ? s[2] : (k == 1) ? s[0] : s[1];
        #1;
        chk("shutdown", {31'h0, e}, {31'h0, shutdown_o});
        if (e) chk("pins", 32'h05, {oe, lvl});
        repeat (4) @(posedge clk_i);
        wb(0, 8'h5c, 0, q);
        chk("flag", {31'h0, e}, {31'h0, q[7]});
        wb(0, 8'h68, 0, q);
        chk("srcview", {28'h0, e, k == 2, k == 1, k == 0}, q);
        ext_int_n_i <= 1'b1;
        comparator_one_i <= 1'b0;
        comparator_two_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("held", {31'h0, e}, {31'h0, shutdown_o});
        wb(1, 8'h5c, {25'h0, s[2:0], 4'h4}, q);
        #1;
        chk("resume", {24'h0, 4'h0, pwm_d_i, pwm_c_i, pwm_b_i, pwm_a_i}, {oe, lvl});
        @(posedge clk_i);
      end
    $display("done sources");
  endtask
  task automatic t_states();
    logic [31:0] q;
    logic la, lb, ta, tb;
    for (int v = 0; v < 16; v++) begin
      wb(1, 8'h5c, {24'h0, 4'h8, v[3:0]}, q);
      ta = v[3];
      tb = v[1];
      la = v[2] & !ta;
      lb = v[0] & !tb;
      #1;
      chk("pins", {24'h0, tb, ta, tb, ta, lb, la, lb, la}, {oe, lvl});
      @(posedge clk_i);
      wb(1, 8'h5c, {28'h0, v[3:0]}, q);
    end
    $display("done pair states");
  endtask
  task automatic t_irq();
    logic [31:0] q;
    wb(1, 8'h64, 32'h0, q);
    wb(1, 8'h5c, 32'h80, q);
    wb(1, 8'h5c, 32'h00, q);
    repeat (3) @(posedge clk_i);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    wb(1, 8'h64, 32'h3, q);
    chk("irq", 32'h1, {31'h0, irq_o});
    wb(0, 8'h60, 0, q);
    chk("status", 32'h3, q);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    $display("done interrupt");
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_src();
    t_states();
    t_irq();
    summarize();
  end
endmodule
bind pas_top pas_top_checker i_chk (.*);
